/* src/swn_dev.sv */
// swn_dev: slave end of the single-wire link, address layer only.
// assumes dq is synchronous to mclk_i and resolved by swn_if.
// How it works
// R1 - crc byte tops address, over 56 bits
// R2 - crc never checked here, sequence continues
// R3 - host checks crc and handles mismatch
// R4 - crc starts zero, family lsb first
// R5 - polynomial x8+x5+x4+1, feedback bit xor stage0
// R6 - line only pulled low, never driven high
// R7 - low beyond 120 us resets, aborts transaction
// R8 - host pauses by leaving line high
// R9 - missing pullup reads as low line
// R10 - suspend needs enable, nonzero select, in window
// R11 - host pullup high active, low for standby
// R12 - reset, address command, function, then data
// R13 - reset answered by presence pulse
// R14 - read opcode 33h or 39h, send address
// R15 - read address only with single slave
// R16 - match address selects only matching device
// R17 - skip opcode selects without comparison
// R18 - skip only with single device
// R19 - search sends bit, complement, reads choice
// R20 - host repeats search for every slave
// R21 - search loser stays silent until reset
// R22 - unknown opcode ignored until next reset
// R23 - family low byte, serial, crc top
// R24 - power mode disabled means never suspend
`timescale 1ns/1ps
module swn_dev import swn_pkg::*; #(
    parameter logic [7:0]  FAMILY         = 8'h5a,          // arbitrary value
    parameter logic [47:0] SERIAL         = 48'h0123_4567_89ab, // arbitrary value
    parameter int          RST_DET_CYC_P  = RST_DET_CYC,
    parameter int          PRES_LOW_CYC_P = PRES_LOW_CYC
) (
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    // link
    swn_if.dev              bus,
    // configuration
    input  wire logic       address_read_opcode_select_i,
    input  wire logic       power_mode_enable_i,
    input  wire logic [1:0] suspend_threshold_select_i,
    input  wire logic       current_in_window_i,
    // user side
    output logic            selected_o,
    output logic            rx_bit_o,
    output logic            rx_valid_o,
    output logic            suspend_o
);
    if (RST_DET_CYC_P < 2 || RST_DET_CYC_P >= (1 << CNT_W) ||
        PRES_LOW_CYC_P < 2 || PRES_LOW_CYC_P >= RST_DET_CYC_P * 4) begin : g_chk
        $error("swn_dev: timing parameters out of range");
    end

    // crc over family and serial, lsb first [R1] [R4] [R5] [R23]
    localparam logic [63:0] ADDR = {swn_crc56({SERIAL, FAMILY}), SERIAL, FAMILY};
    localparam logic [CNT_W-1:0] RST_LIM  = CNT_W'(RST_DET_CYC_P - 1);
    localparam logic [CNT_W-1:0] PW_LIM   = CNT_W'(PRES_WAIT_CYC - 1);
    localparam logic [CNT_W-1:0] PL_LIM   = CNT_W'(PRES_LOW_CYC_P - 1);
    localparam logic [CNT_W-1:0] SAMP_LIM = CNT_W'(DEV_SAMP_CYC - 1);

    typedef enum logic [8:0] {
        D_WAIT   = 9'h001,
        D_RSTSEEN = 9'h002,
        D_PWAIT  = 9'h004,
        D_PRES   = 9'h008,
        D_CMD    = 9'h010,
        D_RDADDR = 9'h020,
        D_MATCH  = 9'h040,
        D_SRCH   = 9'h080,
        D_FUNC   = 9'h100
    } swn_dst_t;

    swn_dst_t         st_q;
    swn_dst_t         op_st;
    logic             dq_q;
    logic             long_q;
    logic             slot_q;
    logic             oe_q;
    logic             mis_q;
    logic             sel_q;
    logic             rxb_q;
    logic             rxv_q;
    logic             susp_q;
    logic [CNT_W-1:0] low_q;
    logic [CNT_W-1:0] slc_q;
    logic [CNT_W-1:0] tc_q;
    logic [5:0]       bit_q;
    logic [1:0]       ph_q;
    logic [7:0]       sr_q;

    wire       dq      = bus.dq;
    wire       fall    = dq_q & ~dq;
    wire       rst_hit = ~dq & (low_q == RST_LIM);
    wire       samp    = slot_q & (slc_q == SAMP_LIM);
    wire       abit    = ADDR[bit_q];
    wire       last    = (bit_q == 6'd63);
    wire       tc_pw   = (tc_q == PW_LIM);
    wire       tc_pl   = (tc_q == PL_LIM);
    wire       srch_tx = (st_q == D_SRCH) & (ph_q != 2'd2);
    wire       tx_now  = (st_q == D_RDADDR) | srch_tx;
    // phase 1 of a search step sends the complement [R19]
    wire       tx_val  = (ph_q == 2'd1) ? ~abit : abit;
    wire       rx_bad  = (dq != abit);
    wire [7:0] rx_byte = {dq, sr_q[7:1]};
    // read opcode follows the select strap [R14]
    wire [7:0] rd_op   = address_read_opcode_select_i ? OP_READ1 : OP_READ0;

    // unknown opcodes park the device until reset [R14] [R16] [R17] [R19] [R22]
    assign op_st = (rx_byte == rd_op)     ? D_RDADDR :
                   (rx_byte == OP_MATCH)  ? D_MATCH  :
                   (rx_byte == OP_SKIP)   ? D_FUNC   :
                   (rx_byte == OP_SEARCH) ? D_SRCH   : D_WAIT;

    // own presence pulse must not count toward the reset length
    always_ff @(posedge mclk_i) begin
        if (rst_i || dq || oe_q) begin
            low_q <= '0;
        end else if (low_q != RST_LIM) begin
            low_q <= low_q + 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            dq_q   <= 1'b1;
            slot_q <= 1'b0;
            slc_q  <= '0;
        end else begin
            dq_q <= dq;
            if (rst_hit || samp) begin
                slot_q <= 1'b0;
            end else if (fall) begin
                slot_q <= 1'b1;
                slc_q  <= '0;
            end else if (slot_q) begin
                slc_q <= slc_q + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            st_q  <= D_WAIT;
            tc_q  <= '0;
            bit_q <= '0;
            ph_q  <= '0;
            sr_q  <= '0;
            mis_q <= 1'b0;
        end else if (rst_hit) begin
            st_q <= D_RSTSEEN; // [R7]
        end else begin
            case (st_q)
                D_RSTSEEN: begin
                    tc_q <= '0;
                    if (dq) begin
                        st_q <= D_PWAIT; // [R13]
                    end
                end
                D_PWAIT: begin
                    tc_q <= tc_pw ? '0 : tc_q + 1'b1;
                    if (tc_pw) begin
                        st_q <= D_PRES;
                    end
                end
                D_PRES: begin
                    tc_q  <= tc_q + 1'b1;
                    bit_q <= '0;
                    if (tc_pl) begin
                        st_q <= D_CMD; // [R12]
                    end
                end
                D_CMD: if (samp) begin
                    sr_q  <= rx_byte;
                    bit_q <= bit_q + 6'd1;
                    ph_q  <= '0;
                    mis_q <= 1'b0;
                    if (bit_q == 6'd7) begin
                        bit_q <= '0;
                        st_q  <= op_st;
                    end
                end
                D_RDADDR: if (samp) begin
                    bit_q <= bit_q + 6'd1;
                    if (last) begin
                        st_q <= D_FUNC; // [R14]
                    end
                end
                D_MATCH: if (samp) begin
                    bit_q <= bit_q + 6'd1;
                    if (rx_bad) begin
                        mis_q <= 1'b1;
                    end
                    if (last) begin
                        st_q <= (mis_q || rx_bad) ? D_WAIT : D_FUNC; // [R16]
                    end
                end
                D_SRCH: if (samp) begin
                    if (ph_q != 2'd2) begin
                        ph_q <= ph_q + 2'd1;
                    end else if (rx_bad) begin
                        st_q <= D_WAIT; // [R21]
                    end else begin
                        ph_q  <= '0;
                        bit_q <= bit_q + 6'd1;
                        if (last) begin
                            st_q <= D_FUNC; // [R19]
                        end
                    end
                end
                D_FUNC, D_WAIT: begin
                end
                default: st_q <= D_WAIT;
            endcase
        end
    end

    // pull low only; a one is sent by leaving the line alone [R6]
    always_ff @(posedge mclk_i) begin
        if (rst_i || rst_hit) begin
            oe_q <= 1'b0;
        end else if (st_q == D_PWAIT) begin
            oe_q <= tc_pw; // [R13]
        end else if (st_q == D_PRES) begin
            oe_q <= ~tc_pl;
        end else if (fall && tx_now && !tx_val) begin
            oe_q <= 1'b1; // [R6]
        end else if (samp) begin
            oe_q <= 1'b0;
        end
    end

    // once selected, bits go straight to the function layer, no crc gate [R2]
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sel_q <= 1'b0;
            rxb_q <= 1'b0;
            rxv_q <= 1'b0;
        end else begin
            sel_q <= (st_q == D_FUNC); // [R2]
            rxv_q <= samp & (st_q == D_FUNC);
            if (samp) begin
                rxb_q <= dq;
            end
        end
    end

    // a lost pullup looks like an endless low line [R9]
    always_ff @(posedge mclk_i) begin
        if (rst_i || dq) begin
            long_q <= 1'b0;
            susp_q <= 1'b0;
        end else begin
            if (rst_hit) begin
                long_q <= 1'b1; // [R9]
            end
            susp_q <= long_q & power_mode_enable_i & // [R10] [R24]
                      (suspend_threshold_select_i != 2'b00) & current_in_window_i;
        end
    end

    assign bus.dev_oe  = oe_q;
    assign bus.dev_out = 1'b0;
    assign selected_o  = sel_q;
    assign rx_bit_o    = rxb_q;
    assign rx_valid_o  = rxv_q;
    assign suspend_o   = susp_q;
endmodule

/* src/swn_host.sv */
// swn_host: bus master end, runs one address command per start request.
// assumes dq is synchronous to mclk_i and resolved by swn_if.
`timescale 1ns/1ps
module swn_host import swn_pkg::*; #(
    parameter int HRST_CYC_P       = HRST_CYC,
    parameter int HPRES_SAMP_CYC_P = HPRES_SAMP_CYC,
    parameter int SLOT_CYC_P       = SLOT_CYC,
    parameter int LOW0_CYC_P       = LOW0_CYC
) (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    // link
    swn_if.host              bus,
    // request
    input  wire logic        start_i,
    input  wire swn_cmd_t    cmd_i,
    input  wire logic [63:0] addr_i,
    input  wire logic        address_read_opcode_select_i,
    input  wire logic        standby_i,
    // answer
    output logic             busy_o,
    output logic             done_o,
    output logic             presence_o,
    output logic [63:0]      addr_o,
    output logic             crc_ok_o
);
    if (HPRES_SAMP_CYC_P >= HRST_CYC_P || LOW0_CYC_P >= SLOT_CYC_P ||
        HSAMP_CYC >= LOW0_CYC_P || HRST_CYC_P >= (1 << CNT_W)) begin : g_chk
        $error("swn_host: timing parameters out of range");
    end

    localparam logic [CNT_W-1:0] RST_LIM  = CNT_W'(HRST_CYC_P - 1);
    localparam logic [CNT_W-1:0] PS_LIM   = CNT_W'(HPRES_SAMP_CYC_P - 1);
    localparam logic [CNT_W-1:0] SLOT_LIM = CNT_W'(SLOT_CYC_P - 1);
    localparam logic [CNT_W-1:0] L0_LIM   = CNT_W'(LOW0_CYC_P - 1);
    localparam logic [CNT_W-1:0] L1_LIM   = CNT_W'(LOW1_CYC - 1);
    localparam logic [CNT_W-1:0] SMP_LIM  = CNT_W'(HSAMP_CYC - 1);

    typedef enum logic [5:0] {
        H_IDLE = 6'h01,
        H_RST  = 6'h02,
        H_PRES = 6'h04,
        H_OP   = 6'h08,
        H_ADDR = 6'h10,
        H_DONE = 6'h20
    } swn_hst_t;

    swn_hst_t         st_q;
    swn_cmd_t         cmd_q;
    logic [CNT_W-1:0] tc_q;
    logic [CNT_W-1:0] slc_q;
    logic             sl_q;
    logic             slw_q;
    logic             slv_q;
    logic             rx_q;
    logic             oe_q;
    logic             b0_q;
    logic             b1_q;
    logic             pres_q;
    logic             done_q;
    logic             busy_q;
    logic             pu_q;
    logic             ok_q;
    logic [5:0]       bit_q;
    logic [1:0]       ph_q;
    logic [7:0]       op_q;
    logic [7:0]       crc_q;
    logic [63:0]      a_q;

    wire       dq      = bus.dq;
    wire       rst_end = (tc_q == RST_LIM);
    wire       sl_end  = sl_q & (slc_q == SLOT_LIM);
    wire       sl_go   = ~sl_q & ((st_q == H_OP) | (st_q == H_ADDR));
    wire [CNT_W-1:0] low_lim = (slw_q & ~slv_q) ? L0_LIM : L1_LIM;
    wire       srch    = (cmd_q == CMD_SEARCH);
    // a 01 or 10 pair names the bit; 00 takes the caller's preference
    wire       dir     = (b0_q != b1_q) ? b0_q : addr_i[bit_q];
    wire       commit  = ~srch | (ph_q == 2'd2);
    wire       nodev   = srch & (ph_q == 2'd2) & b0_q & b1_q; // one pass per start [R20]
    wire       nb      = (cmd_q == CMD_READ) ? rx_q : (cmd_q == CMD_MATCH) ? addr_i[bit_q] : dir;
    wire       wr      = (st_q == H_OP) | (cmd_q == CMD_MATCH) | (srch & ph_q == 2'd2);
    wire       wv      = (st_q == H_OP) ? op_q[bit_q[2:0]] : nb;
    wire [7:0] rd_op   = address_read_opcode_select_i ? OP_READ1 : OP_READ0;
    wire [7:0] op_sel  = (cmd_i == CMD_READ)  ? rd_op :
                         (cmd_i == CMD_MATCH) ? OP_MATCH :
                         (cmd_i == CMD_SKIP)  ? OP_SKIP : OP_SEARCH;

    // time slots, lsb first
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sl_q  <= 1'b0;
            slc_q <= '0;
            slw_q <= 1'b0;
            slv_q <= 1'b0;
            rx_q  <= 1'b0;
            oe_q  <= 1'b0;
        end else begin
            sl_q  <= sl_go | (sl_q & ~sl_end);
            slc_q <= sl_go ? '0 : slc_q + 1'b1;
            if (sl_go) begin
                slw_q <= wr;
                slv_q <= wv;
            end
            if (sl_q && slc_q == SMP_LIM) begin
                rx_q <= dq;
            end
            oe_q <= (st_q == H_IDLE & start_i) | (st_q == H_RST & ~rst_end) | sl_go |
                    (sl_q & oe_q & (slc_q != low_lim)); // released between slots [R8]
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            st_q   <= H_IDLE;
            cmd_q  <= CMD_READ;
            tc_q   <= '0;
            bit_q  <= '0;
            ph_q   <= '0;
            op_q   <= '0;
            b0_q   <= 1'b0;
            b1_q   <= 1'b0;
            pres_q <= 1'b0;
            crc_q  <= CRC_INIT;
            a_q    <= '0;
        end else begin
            tc_q <= tc_q + 1'b1;
            case (st_q)
                H_IDLE: if (start_i) begin
                    cmd_q <= cmd_i;
                    op_q  <= op_sel;
                    tc_q  <= '0;
                    bit_q <= '0;
                    st_q  <= H_RST; // [R12] [R13]
                end
                H_RST: if (rst_end) begin
                    tc_q <= '0;
                    st_q <= H_PRES;
                end
                H_PRES: begin
                    if (tc_q == PS_LIM) begin
                        pres_q <= ~dq; // [R13]
                    end
                    if (rst_end) begin
                        st_q <= pres_q ? H_OP : H_DONE;
                    end
                end
                H_OP: if (sl_end) begin
                    bit_q <= bit_q + 6'd1;
                    ph_q  <= '0;
                    crc_q <= CRC_INIT; // [R4]
                    if (bit_q == 6'd7) begin
                        bit_q <= '0;
                        st_q  <= (cmd_q == CMD_SKIP) ? H_DONE : H_ADDR;
                    end
                end
                H_ADDR: if (sl_end) begin
                    if (!commit) begin
                        ph_q <= ph_q + 2'd1;
                        b0_q <= (ph_q == 2'd0) ? rx_q : b0_q;
                        b1_q <= rx_q; // [R19]
                    end else if (nodev) begin
                        st_q <= H_DONE;
                    end else begin
                        a_q[bit_q] <= nb;
                        ph_q       <= '0;
                        bit_q      <= bit_q + 6'd1;
                        if (bit_q < 6'd56) begin
                            crc_q <= swn_crc_step(crc_q, nb); // [R3] [R5]
                        end
                        if (bit_q == 6'd63) begin
                            st_q <= H_DONE;
                        end
                    end
                end
                H_DONE: st_q <= H_IDLE;
                default: st_q <= H_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            done_q <= 1'b0;
            busy_q <= 1'b0;
            ok_q   <= 1'b0;
            pu_q   <= 1'b1;
        end else begin
            done_q <= (st_q == H_DONE);
            busy_q <= (st_q != H_IDLE);
            pu_q   <= ~standby_i; // [R11]
            if (st_q == H_DONE) begin
                ok_q <= ~nodev & pres_q & (crc_q == a_q[63:56]); // [R3]
            end
        end
    end

    assign bus.host_oe  = oe_q;
    assign bus.host_out = 1'b0;
    assign bus.pu_en    = pu_q;
    assign busy_o       = busy_q;
    assign done_o       = done_q;
    assign presence_o   = pres_q;
    assign addr_o       = a_q;
    assign crc_ok_o     = ok_q;
endmodule

/* src/swn_if.sv */
// swn_if: the shared open-drain data line plus the host's pullup control.
// assumes each end drives only low; the wire level is resolved here.
`timescale 1ns/1ps
interface swn_if;
    logic dev_oe;
    logic dev_out;
    logic host_oe;
    logic host_out;
    logic pu_en;
    wire  dq;

    // wired-and; with the pullup gone the line reads low whatever either end drives [R9]
    assign dq = pu_en & ~(dev_oe & ~dev_out) & ~(host_oe & ~host_out);

    modport dev (input dq, output dev_oe, output dev_out);
    modport host (input dq, output host_oe, output host_out, output pu_en);
endinterface

/* src/swn_pkg.sv */
// swn_pkg: timing, opcodes, crc helpers shared by both ends of the link.
// assumes one 100 MHz clock on each end; all counts derive from it.
package swn_pkg;
    localparam int CLK_MHZ       = 100;
    // line timing in microseconds
    localparam int RST_DET_US    = 120;
    localparam int PRES_WAIT_US  = 30;
    localparam int PRES_LOW_US   = 120;
    localparam int DEV_SAMP_US   = 30;
    localparam int HRST_US       = 480;
    localparam int HPRES_SAMP_US = 70;
    localparam int SLOT_US       = 70;
    localparam int REC_US        = 1;
    localparam int LOW1_US       = 6;
    localparam int LOW0_US       = 60;
    localparam int HSAMP_US      = 13;
    // cycle counts; whole microseconds at whole MHz need no rounding
    localparam int RST_DET_CYC    = RST_DET_US * CLK_MHZ;
    localparam int PRES_WAIT_CYC  = PRES_WAIT_US * CLK_MHZ;
    localparam int PRES_LOW_CYC   = PRES_LOW_US * CLK_MHZ;
    localparam int DEV_SAMP_CYC   = DEV_SAMP_US * CLK_MHZ;
    localparam int HRST_CYC       = HRST_US * CLK_MHZ;
    localparam int HPRES_SAMP_CYC = HPRES_SAMP_US * CLK_MHZ;
    localparam int SLOT_CYC       = (SLOT_US + REC_US) * CLK_MHZ;
    localparam int LOW1_CYC       = LOW1_US * CLK_MHZ;
    localparam int LOW0_CYC       = LOW0_US * CLK_MHZ;
    localparam int HSAMP_CYC      = HSAMP_US * CLK_MHZ;
    localparam int CNT_W          = 20;
    // address layout
    localparam int ADDR_BITS = 64;
    localparam int CRC_SPAN  = 56;
    // address commands
    localparam logic [7:0] OP_READ0  = 8'h33;
    localparam logic [7:0] OP_READ1  = 8'h39;
    localparam logic [7:0] OP_MATCH  = 8'h55;
    localparam logic [7:0] OP_SKIP   = 8'hcc;
    localparam logic [7:0] OP_SEARCH = 8'hf0;
    // x^8+x^5+x^4+1, reflected for lsb-first shifting
    localparam logic [7:0] CRC_INIT  = 8'h00;
    localparam logic [7:0] CRC_FB    = 8'h8c;

    typedef enum logic [1:0] {
        CMD_READ   = 2'h0,
        CMD_MATCH  = 2'h1,
        CMD_SKIP   = 2'h2,
        CMD_SEARCH = 2'h3
    } swn_cmd_t;

    function automatic logic [7:0] swn_crc_step(input logic [7:0] crc, input logic b);
        swn_crc_step = (crc >> 1) ^ ((crc[0] ^ b) ? CRC_FB : 8'h00);
    endfunction

    function automatic logic [7:0] swn_crc56(input logic [55:0] d);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 0; i < CRC_SPAN; i++) begin
            c = swn_crc_step(c, d[i]);
        end
        swn_crc56 = c;
    endfunction
endpackage

/* verification/single_wire_net_address_layer_tb.sv */
// single_wire_net_address_layer_tb: both ends joined, skip and suspend runs.
// assumes shortened line timing; fixed 3000-cycle waits stay as they are.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module single_wire_net_address_layer_tb import swn_pkg::*;;
    localparam int RDET   = 5000;
    localparam int PLOW   = 4500;
    localparam int HRST   = 8000;
    localparam int HPSAMP = 4000;
    localparam int HSLOT  = 3200;
    localparam int HLOW0  = 3050;
    logic        mclk_i    = 1'b0;
    logic        rst_i     = 1'b1;
    logic        start_i   = 1'b0;
    swn_cmd_t    cmd_i     = CMD_SKIP;
    logic        standby_i = 1'b0;
    logic        pme_i     = 1'b0;
    logic [1:0]  sel_i     = 2'h0;
    logic        win_i     = 1'b0;
    logic        busy_o;
    logic        done_o;
    logic        presence_o;
    logic        crc_ok_o;
    logic        selected_o;
    logic        suspend_o;
    logic [63:0] addr_o;
    logic        rx_bit_o;
    logic        rx_valid_o;
    logic        rdsel     = 1'b1;
    logic [63:0] pref_addr = 64'h0;
    int          num_errors = 0;
    int          tests_run  = 0;
    int          rx_cnt     = 0;
    // pme, select, window; expected suspend on top
    logic [4:0]  rows [4] = '{5'h1b, 5'h07, 5'h09, 5'h0c};

    always #5 mclk_i = ~mclk_i;

    // function-layer bits handed up while selected
    always @(posedge mclk_i) begin
        if (rx_valid_o === 1'b1) begin
            rx_cnt++;
        end
    end

    swn_if bus (); // a single device on the line
    swn_dev #(.RST_DET_CYC_P(RDET), .PRES_LOW_CYC_P(PLOW)) i_swn_dev (
        .mclk_i(mclk_i), .rst_i(rst_i), .bus(bus), .address_read_opcode_select_i(rdsel),
        .power_mode_enable_i(pme_i), .suspend_threshold_select_i(sel_i),
        .current_in_window_i(win_i), .selected_o(selected_o), .rx_bit_o(rx_bit_o),
        .rx_valid_o(rx_valid_o), .suspend_o(suspend_o));
    swn_host #(.HRST_CYC_P(HRST), .HPRES_SAMP_CYC_P(HPSAMP), .SLOT_CYC_P(HSLOT),
        .LOW0_CYC_P(HLOW0)) i_swn_host (
        .mclk_i(mclk_i), .rst_i(rst_i), .bus(bus), .start_i(start_i), .cmd_i(cmd_i),
        .addr_i(pref_addr), .address_read_opcode_select_i(rdsel), .standby_i(standby_i),
        .busy_o(busy_o), .done_o(done_o), .presence_o(presence_o), .addr_o(addr_o),
        .crc_ok_o(crc_ok_o));
    swn_link_properties #(.RST_DET_CYC_P(RDET), .PRES_LOW_CYC_P(PLOW), .HRST_CYC_P(HRST),
        .LOW0_CYC_P(HLOW0)) i_swn_link_properties (
        .mclk_i(mclk_i), .rst_i(rst_i), .dq(bus.dq), .dev_oe(bus.dev_oe),
        .dev_out(bus.dev_out), .host_oe(bus.host_oe), .host_out(bus.host_out),
        .pu_en(bus.pu_en));

    task automatic complete_run();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // one start pulse, then a bounded wait for done
    task automatic run_cmd(input swn_cmd_t c);
        int n;
        n = 0;
        cmd_i   <= c;
        start_i <= 1'b1;
        @(posedge mclk_i);
        start_i <= 1'b0;
        while (done_o !== 1'b1 && n < 60000) begin
            @(posedge mclk_i);
            n++;
        end
        `CHK("done_seen", 1'b1, done_o)
    endtask

    initial begin
        repeat (10) @(posedge mclk_i);
        `CHK("reset_pullup", 1'b1, bus.pu_en)
        rst_i <= 1'b0;
        @(posedge mclk_i);
        run_cmd(CMD_SKIP);
        `CHK("presence", 1'b1, presence_o)
        `CHK("skip_selected", 1'b1, selected_o)
        `CHK("skip_no_addr", 64'h0, addr_o)
        `CHK("no_func_bits", 0, rx_cnt)
        `CHK("line_idle", 1'b1, bus.dq)
        `CHK("no_suspend", 1'b0, suspend_o)
        foreach (rows[i]) begin
            {pme_i, sel_i, win_i} <= rows[i][3:0];
            standby_i             <= 1'b1;
            repeat (RDET + 50) @(posedge mclk_i);
            `CHK("pullup_off_dq", 1'b0, bus.dq)
            `CHK("host_idle", 1'b0, busy_o)
            `CHK("suspend_entry", rows[i][4], suspend_o)
            standby_i <= 1'b0;
            repeat (50) @(posedge mclk_i);
            `CHK("pullup_on", 1'b1, bus.pu_en)
            `CHK("suspend_exit", 1'b0, suspend_o)
            repeat (8000) @(posedge mclk_i);
        end
        // only the first low line lands while still selected
        `CHK("func_bits", 1, rx_cnt)
        `CHK("func_bit_low", 1'b0, rx_bit_o)
        complete_run();
    end

    // skip run plus four suspend rows come to about 94000 cycles
    initial begin
        repeat (98000) @(posedge mclk_i);
        num_errors++;
        complete_run();
    end
endmodule

/* verification/swn_link_properties.sv */
// swn_link_properties: timing checks on the shared line between both ends.
// assumes swn_if signals, one clock, synchronous active high reset.
`timescale 1ns/1ps
module swn_link_properties import swn_pkg::*; #(
    parameter int RST_DET_CYC_P  = RST_DET_CYC,
    parameter int PRES_LOW_CYC_P = PRES_LOW_CYC,
    parameter int HRST_CYC_P     = HRST_CYC,
    parameter int LOW0_CYC_P     = LOW0_CYC
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // line
    input wire       dq,
    input wire logic dev_oe,
    input wire logic dev_out,
    input wire logic host_oe,
    input wire logic host_out,
    input wire logic pu_en
);
    localparam int PW_LO = PRES_WAIT_CYC - 10;
    localparam int PW_HI = PRES_WAIT_CYC + 10;
    logic [CNT_W-1:0] host_run_q;
    logic [CNT_W-1:0] dev_run_q;
    logic [CNT_W-1:0] rel_q;
    // host just let go after a full reset pulse
    wire              rst_end = !host_oe && (host_run_q >= HRST_CYC_P - 2);
    wire              rel_on  = (rel_q != '0) && (rel_q <= PW_HI);

    always_ff @(posedge mclk_i) begin
        host_run_q <= (rst_i || !host_oe) ? '0 : host_run_q + 1'b1;
        dev_run_q  <= (rst_i || !dev_oe) ? '0 : dev_run_q + 1'b1;
        rel_q      <= rst_i ? '0 : (rst_end ? CNT_W'(1) : (rel_on ? rel_q + 1'b1 : '0));
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence s_rst_done;
        rel_q != '0 && rel_q < PW_LO;
    endsequence
    sequence s_pres_end;
        $fell(dev_oe) && dev_run_q > DEV_SAMP_CYC + 10;
    endsequence

    dev_low_only_a: assert property (dev_out == 1'b0)
        else $error("device drives the line high");
    pulldown_wins_a: assert property (!pu_en |-> !dq)
        else $error("line not low with pullup removed");
    standby_quiet_a: assert property (!pu_en |-> !host_oe && !dev_oe)
        else $error("line pulled during standby");
    reset_abort_a: assert property (host_run_q >= RST_DET_CYC_P |-> !dev_oe)
        else $error("device pulls during reset pulse");
    pres_early_a: assert property (s_rst_done |-> !dev_oe)
        else $error("presence starts too early");
    pres_start_a: assert property (rel_q == PW_HI |-> dev_oe)
        else $error("presence missing after reset");
    pres_len_a: assert property (s_pres_end |->
        dev_run_q inside {[PRES_LOW_CYC_P - 2:PRES_LOW_CYC_P + 2]})
        else $error("presence length wrong");
    pres_max_a: assert property (dev_run_q <= PRES_LOW_CYC_P + 2)
        else $error("device holds the line too long");
    slot_low_a: assert property ($fell(host_oe) |-> host_run_q inside
        {[LOW1_CYC - 2:LOW1_CYC + 2], [LOW0_CYC_P - 2:LOW0_CYC_P + 2],
         [HRST_CYC_P - 2:HRST_CYC_P + 2]})
        else $error("host low time is no slot or reset");
endmodule
